// *** bcast_checker.sv ***
// Port assertions for the broadcast master.
// Assumes the bind below attaches it to every bcast_master.
module bcast_checker import bcast_pkg::*; #(
	parameter int unsigned GAP_COUNT = GAP_CLKS
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic enable,
	input wire logic [15:0] reg_addr,
	input wire logic tx_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic field_active,
	input wire logic inhibited,
	input wire logic addr_error
);
	// ==========
	// Byte position
	logic [2:0] idx;
	logic bad;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	assign bad = reg_addr < REG_ADDR_MIN || reg_addr > REG_ADDR_MAX;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			idx <= 3'h0;
		end else if (tx_valid && tx_ready) begin
			idx <= idx + 3'h1;
		end
	end
	// Idle cycles since the last byte of a frame; starts saturated so the first frame passes.
	logic [31:0] gap_cnt;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			gap_cnt <= 32'hFFFFFFFF;
		end else if (tx_valid && tx_ready && idx == LAST_BYTE) begin
			gap_cnt <= 32'h00000000;
		end else if (!tx_valid && gap_cnt != 32'hFFFFFFFF) begin
			gap_cnt <= gap_cnt + 32'h00000001;
		end
	end
	a_gap_length: assert property ($rose(tx_valid) && idx == 3'h0 |-> gap_cnt >= 32'(GAP_COUNT))
		else $error("frame gap too short");
	a_hold_until_ready: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("byte not held");
	a_drop_after_take: assert property (tx_valid && tx_ready |=> !tx_valid)
		else $error("valid held after take");
	a_frame_gap: assert property (tx_valid && tx_ready && idx == LAST_BYTE |=> !tx_valid [*8])
		else $error("no gap after frame");
	a_addr_flag: assert property (1'b1 |=> addr_error == $past(bad))
		else $error("address flag wrong");
	a_slave_zero: assert property (tx_valid && idx == 3'h0 |-> tx_data == BCAST_ADDR)
		else $error("slave address wrong");
	a_func_code: assert property (tx_valid && idx == 3'h1 |-> tx_data == FUNC_WRITE_SINGLE)
		else $error("function code wrong");
	a_cfg_exclusive: assert property ($rose(tx_valid) |-> field_active)
		else $error("byte while config port active");
	a_inhibit_stops: assert property ($rose(tx_valid) && idx == 3'h0 |-> !$past(inhibited))
		else $error("frame while inhibited");
	a_enable_gates: assert property ($rose(tx_valid) && idx == 3'h0 |-> $past(enable, 2))
		else $error("frame while disabled");
	c_frame: cover property ($rose(tx_valid) && idx == 3'h0);
	c_inhibit: cover property ($rose(inhibited));
	c_bad_addr: cover property ($rose(addr_error));
endmodule // bcast_checker

bind bcast_master bcast_checker #(.GAP_COUNT(GAP_COUNT)) u_chk (.clk(clk), .rstn(rstn),
	.enable(enable), .reg_addr(reg_addr), .tx_ready(tx_ready), .tx_valid(tx_valid),
	.tx_data(tx_data), .field_active(field_active), .inhibited(inhibited),
	.addr_error(addr_error));

// *** bcast_crc.sv ***
// Frame check engine for the serial field link, one byte per cycle.
// Assumes the user clears it before the first byte of every frame.
module bcast_crc import bcast_pkg::*; (
	input wire logic clk,
	input wire logic rstn,
	crc_if.engine port
);
	logic [15:0] crc_reg;
	logic [15:0] crc_next;

	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	always_comb begin
		crc_next = crc_reg;
		if (port.clear) begin
			crc_next = CRC_INIT;
		end else if (port.feed) begin
			crc_next = crc_byte(crc_reg, port.data);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			crc_reg <= CRC_INIT;
		end else begin
			crc_reg <= crc_next;
		end
	end

	assign port.crc = crc_reg;
endmodule // bcast_crc

// *** bcast_master.sv ***
// Broadcast retransmission master: frames one selected quantity as a write-single-register
// broadcast once per control cycle and hands the bytes to an external UART.
// Assumes the UART accepts a byte when tx_valid and tx_ready are both high.
//
// Summary of operation
// - Field link frames follow RTU framing rules.
// - Config port and field port never concurrently; code only holds off new frames, a frame under way still runs to its end.
// - Value sent as scaled integer, no point.
// - Broadcasts use write single register function.
// - Target register address configurable 1 to 9999.
// - No reply awaited; slaves stay silent.
// - Select setpoint, process, output or error.
// - Valid external master request stops broadcasts; code takes any rising edge of master_request held for two clocks and only holds off new frames.
// - Every parameter has its own distinct address.
// - Send selected value once every control cycle.
// - Resume thirty seconds after master goes quiet.
// - Value encoded as signed sixteen-bit integer.
module bcast_master import bcast_pkg::*; #(
	parameter int unsigned CYCLE_COUNT = CYCLE_CLKS,
	parameter int unsigned QUIET_COUNT = QUIET_CLKS,
	parameter int unsigned GAP_COUNT = GAP_CLKS
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic enable,
	input wire logic [1:0] source_sel,
	input wire logic [15:0] reg_addr,
	input wire logic signed [15:0] target_setpoint,
	input wire logic signed [15:0] process_value,
	input wire logic signed [15:0] output_demand,
	input wire logic signed [15:0] control_error,
	input wire logic master_request,
	input wire logic config_active,
	input wire logic tx_ready,
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic field_active,
	output logic inhibited,
	output logic addr_error
);
	// A whole frame must fit inside one control cycle, so very short cycles are refused here.
	if (CYCLE_COUNT < 64 || QUIET_COUNT < 1 || GAP_COUNT < 1) begin : g_bad_counts
		$error("bcast_master: counts too small");
	end

	crc_if crc_bus();
	bcast_crc u_crc (
		.clk(clk),
		.rstn(rstn),
		.port(crc_bus.engine)
	);

	// =====================================================================
	// Input synchronisers for pin-level signals
	// =====================================================================
	logic [2:0] req_sync_reg, req_sync_next;
	logic [2:0] cfg_sync_reg, cfg_sync_next;
	logic req_level_reg, req_level_next;
	logic cfg_level_reg, cfg_level_next;
	logic req_seen;

	always_comb begin
		req_sync_next = {req_sync_reg[1:0], master_request};
		cfg_sync_next = {cfg_sync_reg[1:0], config_active};
		req_level_next = req_level_reg;
		cfg_level_next = cfg_level_reg;
		if (req_sync_reg[1] == req_sync_reg[2]) begin
			req_level_next = req_sync_reg[2];
		end
		if (cfg_sync_reg[1] == cfg_sync_reg[2]) begin
			cfg_level_next = cfg_sync_reg[2];
		end
	end

	assign req_seen = req_level_next & ~req_level_reg;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			req_sync_reg <= 3'h0;
			cfg_sync_reg <= 3'h0;
			req_level_reg <= 1'b0;
			cfg_level_reg <= 1'b0;
		end else begin
			req_sync_reg <= req_sync_next;
			cfg_sync_reg <= cfg_sync_next;
			req_level_reg <= req_level_next;
			cfg_level_reg <= cfg_level_next;
		end
	end

	// =====================================================================
	// Inhibit timer and cycle timer
	// =====================================================================
	logic [31:0] quiet_reg, quiet_next;
	logic [31:0] cycle_reg, cycle_next;
	logic inhibit_reg, inhibit_next;
	logic tick;

	assign tick = (cycle_reg == 32'(CYCLE_COUNT - 1));

	always_comb begin
		quiet_next = quiet_reg;
		inhibit_next = inhibit_reg;
		cycle_next = tick ? 32'h0 : cycle_reg + 32'h1;
		if (req_seen) begin
			inhibit_next = 1'b1;
			quiet_next = 32'h0;
		end else if (inhibit_reg) begin
			if (quiet_reg == 32'(QUIET_COUNT - 1)) begin
				inhibit_next = 1'b0;
			end else begin
				quiet_next = quiet_reg + 32'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			quiet_reg <= 32'h0;
			cycle_reg <= 32'h0;
			inhibit_reg <= 1'b0;
		end else begin
			quiet_reg <= quiet_next;
			cycle_reg <= cycle_next;
			inhibit_reg <= inhibit_next;
		end
	end

	// =====================================================================
	// Frame sequencer
	// =====================================================================
	state_t state_reg, state_next;
	logic [7:0] frame_reg [0:5];
	logic [7:0] frame_next [0:5];
	logic [2:0] idx_reg, idx_next;
	logic [31:0] gap_reg, gap_next;
	logic tx_valid_reg, tx_valid_next;
	logic [7:0] tx_data_reg, tx_data_next;
	logic addr_ok;
	logic go;
	logic signed [15:0] value;

	// Out-of-range addresses are refused rather than clipped, so no stray register is hit.
	assign addr_ok = (reg_addr >= REG_ADDR_MIN) && (reg_addr <= REG_ADDR_MAX);
	assign go = tick && enable && !inhibit_reg && !cfg_level_reg && addr_ok;

	always_comb begin
		case (source_t'(source_sel))
			SRC_SETPOINT: value = target_setpoint;
			SRC_PROCESS: value = process_value;
			SRC_OUTPUT: value = output_demand;
			SRC_ERROR: value = control_error;
			default: value = target_setpoint;
		endcase
	end

	always_comb begin
		state_next = state_reg;
		frame_next = frame_reg;
		idx_next = idx_reg;
		gap_next = gap_reg;
		tx_valid_next = tx_valid_reg;
		tx_data_next = tx_data_reg;
		crc_bus.clear = 1'b0;
		crc_bus.feed = 1'b0;
		crc_bus.data = tx_data_reg;
		case (state_reg)
			ST_IDLE: begin
				if (go) begin
					frame_next[0] = BCAST_ADDR;
					frame_next[1] = FUNC_WRITE_SINGLE;
					// Protocol register numbers are one-based; the wire carries them less one.
					frame_next[2] = 8'(16'(reg_addr - 16'h1) >> 8);
					frame_next[3] = 8'(reg_addr - 16'h1);
					frame_next[4] = value[15:8];
					frame_next[5] = value[7:0];
					crc_bus.clear = 1'b1;
					idx_next = 3'h0;
					state_next = ST_LOAD;
				end
			end
			ST_LOAD: begin
				tx_data_next = (idx_reg < 3'h6) ? frame_reg[idx_reg] :
					(idx_reg == 3'h6 ? crc_bus.crc[7:0] : crc_bus.crc[15:8]);
				tx_valid_next = 1'b1;
				state_next = ST_SEND;
			end
			ST_SEND: begin
				if (tx_ready) begin
					tx_valid_next = 1'b0;
					crc_bus.feed = (idx_reg < 3'h6);
					if (idx_reg == LAST_BYTE) begin
						gap_next = 32'h0;
						state_next = ST_GAP;
					end else begin
						idx_next = idx_reg + 3'h1;
						state_next = ST_LOAD;
					end
				end
			end
			ST_GAP: begin
				// Silent interval ends the frame; no reply is listened for.
				if (gap_reg == 32'(GAP_COUNT - 1)) begin
					state_next = ST_IDLE;
				end else begin
					gap_next = gap_reg + 32'h1;
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= ST_IDLE;
			for (int i = 0; i < 6; i++) begin
				frame_reg[i] <= 8'h00;
			end
			idx_reg <= 3'h0;
			gap_reg <= 32'h0;
			tx_valid_reg <= 1'b0;
			tx_data_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			frame_reg <= frame_next;
			idx_reg <= idx_next;
			gap_reg <= gap_next;
			tx_valid_reg <= tx_valid_next;
			tx_data_reg <= tx_data_next;
		end
	end

	// =====================================================================
	// Registered status outputs
	// =====================================================================
	logic field_reg, inh_out_reg, addr_err_reg;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			field_reg <= 1'b0;
			inh_out_reg <= 1'b0;
			addr_err_reg <= 1'b0;
		end else begin
			field_reg <= !cfg_level_reg;
			inh_out_reg <= inhibit_reg;
			addr_err_reg <= !addr_ok;
		end
	end

	assign tx_valid = tx_valid_reg;
	assign tx_data = tx_data_reg;
	assign field_active = field_reg;
	assign inhibited = inh_out_reg;
	assign addr_error = addr_err_reg;
endmodule // bcast_master

// *** bcast_pkg.sv ***
// Shared constants and types for the broadcast retransmission master.
// Assumes a single 40 MHz clock domain and an external UART that takes one byte at a time.
package bcast_pkg;
	localparam int unsigned CLK_HZ = 40000000;
	localparam int unsigned CYCLE_MS = 250;
	localparam int unsigned CYCLE_CLKS = CLK_HZ / 1000 * CYCLE_MS;
	localparam int unsigned QUIET_S = 30;
	localparam int unsigned QUIET_CLKS = CLK_HZ * QUIET_S;
	localparam int unsigned GAP_CLKS = 3646;
	localparam logic [7:0] BCAST_ADDR = 8'h00;
	localparam logic [7:0] FUNC_WRITE_SINGLE = 8'h06;
	localparam logic [15:0] REG_ADDR_MIN = 16'h0001;
	localparam logic [15:0] REG_ADDR_MAX = 16'h270F;
	localparam logic [15:0] REG_ADDR_RESET = 16'h0001;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'hA001;
	localparam int unsigned FRAME_BYTES = 8;
	localparam logic [2:0] LAST_BYTE = 3'h7;

	typedef enum logic [1:0] {
		SRC_SETPOINT = 2'h0,
		SRC_PROCESS = 2'h1,
		SRC_OUTPUT = 2'h2,
		SRC_ERROR = 2'h3
	} source_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_LOAD = 4'b0010,
		ST_SEND = 4'b0100,
		ST_GAP = 4'b1000
	} state_t;
endpackage

// *** crc_if.sv ***
// Carrier between the framer and its checksum engine.
// Assumes both ends share one clock.
interface crc_if;
	logic clear;
	logic feed;
	logic [7:0] data;
	logic [15:0] crc;
	modport engine (input clear, input feed, input data, output crc);
	modport user (output clear, output feed, output data, input crc);
endinterface

// *** field_partner.sv ***
// Field link model: a UART that takes bytes with random stalls.
// Assumes a byte moves on each edge where tx_valid and tx_ready are high.
module field_partner (
	input wire logic clk,
	input wire logic rstn,
	output logic tx_ready
);
	// ==========
	// Pacing
	// Slaves share the decimal resolution, accept function 6 and never answer,
	// so there is no path back into the block.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tx_ready <= 1'b0;
		end else begin
			tx_ready <= ($urandom % 3) != 0;
		end
	end
endmodule // field_partner

// *** modbus_broadcast_retransmit_tb.sv ***
// Self-checking bench for bcast_master with shortened counts.
// Assumes field_partner paces bytes and the checker is bound to the design.
module modbus_broadcast_retransmit_tb import bcast_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0, rstn = 1'b0, enable = 1'b1, master_request = 1'b0, config_active = 1'b0;
	logic tx_ready, tx_valid, field_active, inhibited, addr_error;
	logic [1:0] source_sel = 2'h0;
	logic [15:0] reg_addr = 16'h0001;
	logic [7:0] tx_data;
	logic signed [15:0] vals [4] = '{default: 16'h0000};
	logic [7:0] expq [$];
	int mismatches = 0, samples_checked = 0;
	bcast_master #(.CYCLE_COUNT(200), .QUIET_COUNT(500), .GAP_COUNT(10)) u_dut (
		.clk(clk), .rstn(rstn), .enable(enable), .source_sel(source_sel), .reg_addr(reg_addr),
		.target_setpoint(vals[0]), .process_value(vals[1]), .output_demand(vals[2]),
		.control_error(vals[3]), .master_request(master_request), .config_active(config_active),
		.tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
		.field_active(field_active), .inhibited(inhibited), .addr_error(addr_error));
	field_partner u_partner (.clk(clk), .rstn(rstn), .tx_ready(tx_ready));
	initial begin
		forever #12.5 clk = ~clk;
	end
	// ==========
	// Tasks
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Queues the eight bytes of one frame, checksum worked out bit by bit.
	task automatic expect_frame();
		logic [7:0] f [6];
		logic [15:0] a, v, c;
		a = reg_addr - 16'h0001;
		v = vals[source_sel];
		f = '{BCAST_ADDR, FUNC_WRITE_SINGLE, a[15:8], a[7:0], v[15:8], v[7:0]};
		c = CRC_INIT;
		foreach (f[i]) begin
			expq.push_back(f[i]);
			c ^= {8'h00, f[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
		end
		expq.push_back(c[7:0]);
		expq.push_back(c[15:8]);
	endtask
	task automatic drain(input int n);
		while (expq.size() != 0 && n > 0) begin
			@(negedge clk);
			n--;
		end
		chk("bytes left", 16'h0000, 16'(expq.size()));
	endtask
	// ==========
	// Watcher and limit
	always @(posedge clk) begin
		if (rstn && tx_valid && tx_ready) begin
			if (expq.size() == 0) chk("unexpected byte", 16'hFFFF, {8'h00, tx_data});
			else chk("byte", {8'h00, expq.pop_front()}, {8'h00, tx_data});
		end
	end
	initial begin
		repeat (12000) @(posedge clk);
		mismatches++;
		give_verdict();
	end
	// ==========
	// Scenarios
	initial begin
		void'($urandom(59409));
		idle(2);
		rstn = 1'b1;
		for (int i = 0; i < 6; i++) begin
			foreach (vals[k]) vals[k] = 16'($urandom);
			source_sel = 2'(i);
			reg_addr = (i == 4) ? REG_ADDR_MAX : 16'($urandom_range(9999, 1));
			expect_frame();
			drain(400);
		end
		// Each case blocks broadcasts; the watcher flags any byte that slips out.
		// Enable returns only after the synchronised config level has settled, so no tick slips.
		for (int i = 0; i < 4; i++) begin
			enable = 1'b0;
			config_active = (i == 1);
			reg_addr = (i == 2) ? 16'h0000 : (i == 3) ? 16'h2710 : REG_ADDR_MIN;
			idle(8);
			enable = (i != 0);
			chk("field_active", {15'h0000, i != 1}, {15'h0000, field_active});
			chk("addr_error", {15'h0000, i >= 2}, {15'h0000, addr_error});
			idle(450);
		end
		reg_addr = REG_ADDR_MIN;
		expect_frame();
		drain(400);
		master_request = 1'b1;
		idle(2);
		master_request = 1'b0;
		idle(8);
		chk("inhibited", 16'h0001, {15'h0000, inhibited});
		idle(460);
		chk("inhibited", 16'h0001, {15'h0000, inhibited});
		expect_frame();
		idle(70);
		chk("inhibited", 16'h0000, {15'h0000, inhibited});
		drain(400);
		give_verdict();
	end
endmodule // modbus_broadcast_retransmit_tb
